// >>> gcs_switchover_mux.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - runt-free switch completes within 17 cycles of the new clock.
// - with suppression strapped off, select switches the input at once.
// - a too-weak selected input holds the output at its last level.
// - floating or static input gives a steady output, never odd levels.
// - running switch: follow old, then low for new pulses, then new.
// - old stuck high: high for new pulses, low for falls, then new.
// - stretched cycle high and low each exceed half a new period.
// - old stuck low: low for some new falling edges, then new.
// - failed weak input switches by its last valid level.
// - both inputs handled identically, either may be primary.
// - select is asynchronous and synchronised; stage counts may vary.
// - enable low: output goes low after next falling edge.
// - enable high: output resumes after next falling edge.
// - power-on reset puts the switch machine in a known state.
module gcs_switchover_mux (
  input wire logic clk, // system clock, 50 MHz
  input wire logic sys_rst, // async reset, high
  input wire logic ce, // clock enable, freezes all
  input wire logic clockInputA, // first clock input
  input wire logic clockInputB, // second clock input
  input wire logic ampOkA, // input a swing is valid
  input wire logic ampOkB, // input b swing is valid
  input wire logic select, // async select, 0 = a
  input wire logic enable, // output enable, high
  input wire logic porDelayStrap, // high: runt suppression off
  output gcs_pkg::gcs_fanout_type fanout, // ten outputs
  output logic runtSuppression, // suppression active
  output logic switchBusy // switchover in progress
);
  import gcs_pkg::*;

  // ==========================================================
  // choose one observation by index
  function automatic gcs_obs_type pick_obs(
    input logic sel,
    input gcs_obs_type a,
    input gcs_obs_type b
  );
    pick_obs = sel ? b : a;
  endfunction

  gcs_obs_type obsA;
  gcs_obs_type obsB;
  gcs_state_type state;
  gcs_state_type next_state;
  logic curSel;
  logic next_curSel;
  logic [2:0] cnt;
  logic [2:0] next_cnt;
  logic [2:0] deadCnt;
  logic [2:0] next_deadCnt;
  logic selMeta;
  logic selSync;
  logic strapTaken;
  logic bypass;
  logic muxLevel;

  // ==========================================================
  // input observers, one per input, identical
  gcs_edge_track u_track_a (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .clockPin(clockInputA),
    .ampOk(ampOkA),
    .obs(obsA)
  );

  gcs_edge_track u_track_b (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .clockPin(clockInputB),
    .ampOk(ampOkB),
    .obs(obsB)
  );

  // followed input and the other one
  wire gcs_obs_type selObs = pick_obs(curSel, obsA, obsB);
  wire gcs_obs_type othObs = pick_obs(~curSel, obsA, obsB);
  wire wantSwitch = selSync != curSel;
  wire drainDone = selObs.fall && cnt == DRAIN_PULSES - 3'h1;
  wire oldDead = othObs.rise && !selObs.rise &&
    deadCnt == DEAD_NEW_EDGES - 3'h1;

  // ==========================================================
  // select synchroniser, the first flop feeds only the second
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      selMeta <= SEL_RESET;
      selSync <= SEL_RESET;
    end else if (ce) begin
      selMeta <= select;
      selSync <= selMeta;
    end
  end

  // ==========================================================
  // strap is caught once, on the first enabled edge after reset
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      strapTaken <= 1'h0;
      bypass <= STRAP_RESET;
    end else if (ce && !strapTaken) begin
      strapTaken <= 1'h1;
      bypass <= porDelayStrap;
    end
  end

  // ==========================================================
  // switchover sequencing; every count step is gated by an
  // edge of an input clock, never by the system clock alone
  always_comb begin
    next_state = state;
    next_curSel = curSel;
    next_cnt = cnt;
    next_deadCnt = deadCnt;
    case (state)
      ST_FOLLOW: begin
        if (!strapTaken) begin
          next_curSel = curSel;
        end else if (bypass) begin
          next_curSel = selSync;
        end else if (wantSwitch) begin
          next_state = ST_DRAIN;
          next_cnt = CNT_RESET;
          next_deadCnt = CNT_RESET;
        end
      end
      ST_DRAIN: begin
        // select went back before the old clock was dropped
        if (!wantSwitch) begin
          next_state = ST_FOLLOW;
        end else if (drainDone) begin
          next_state = ST_HOLD_LOW;
          next_curSel = ~curSel;
          next_cnt = CNT_RESET;
        end else if (selObs.fall || selObs.rise) begin
          next_cnt = selObs.fall ? cnt + 3'h1 : cnt;
          next_deadCnt = CNT_RESET;
        end else if (oldDead) begin
          // old input silent: branch on its last valid level
          next_state = selObs.level ? ST_HOLD_HIGH : ST_HOLD_LOW;
          next_curSel = ~curSel;
          next_cnt = CNT_RESET;
        end else if (othObs.rise) begin
          next_deadCnt = deadCnt + 3'h1;
        end
      end
      ST_HOLD_HIGH: begin
        // leave high only on a new fall after full pulses
        if (selObs.fall && cnt == HIGH_HOLD_PULSES) begin
          next_state = ST_HOLD_LOW;
          next_cnt = CNT_RESET;
        end else if (selObs.rise && cnt != HIGH_HOLD_PULSES) begin
          next_cnt = cnt + 3'h1;
        end
      end
      ST_HOLD_LOW: begin
        if (selObs.fall) begin
          next_cnt = cnt + 3'h1;
          if (cnt == LOW_EDGES - 3'h1) begin
            next_state = ST_FOLLOW;
          end
        end
      end
      default: begin
        next_state = ST_FOLLOW;
      end
    endcase
  end

  // ==========================================================
  // machine state, known after reset
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= ST_FOLLOW;
      curSel <= SEL_RESET;
      cnt <= CNT_RESET;
      deadCnt <= CNT_RESET;
    end else if (ce) begin
      state <= next_state;
      curSel <= next_curSel;
      cnt <= next_cnt;
      deadCnt <= next_deadCnt;
    end
  end

  // ==========================================================
  // output level: follow the chosen input or hold a stage level
  wire following = state == ST_FOLLOW || state == ST_DRAIN;
  assign muxLevel = following ? selObs.level :
    state == ST_HOLD_HIGH;

  gcs_out_gate u_gate (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .enable(enable),
    .muxLevel(muxLevel),
    .fanout(fanout)
  );

  // status, combinational from registered state
  assign runtSuppression = strapTaken & ~bypass;
  assign switchBusy = state != ST_FOLLOW;

  // ==========================================================
  // helper: new-clock rises seen since the switch began
  logic [4:0] swRises;
  wire tgtRise = state == ST_DRAIN ? othObs.rise : selObs.rise;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      swRises <= 5'h00;
    end else if (ce) begin
      if (state == ST_FOLLOW) begin
        swRises <= 5'h00;
      end else if (tgtRise && swRises != 5'h1F) begin
        swRises <= swRises + 5'h01;
      end
    end
  end

  // ==========================================================
  // checks
  a_switch_bound: assert property (
    @(posedge clk) disable iff (sys_rst)
    swRises <= SWITCH_MAX_CYCLES)
    else $error("switchover took more than 17 new cycles");

  a_bypass_direct: assert property (
    @(posedge clk) disable iff (sys_rst)
    (bypass && strapTaken && ce) |=>
      curSel == $past(selSync) && state == ST_FOLLOW)
    else $error("plain mux did not follow select");

  a_drain_low: assert property (
    @(posedge clk) disable iff (sys_rst)
    ($past(state) == ST_DRAIN && state == ST_HOLD_LOW &&
      $past(selObs.fall)) |-> curSel != $past(curSel))
    else $error("old clock not dropped on its fall");

  a_hold_levels: assert property (
    @(posedge clk) disable iff (sys_rst)
    (state == ST_HOLD_HIGH |-> muxLevel) and
    (state == ST_HOLD_LOW |-> !muxLevel))
    else $error("stage level wrong during switchover");

  a_stretch_exit: assert property (
    @(posedge clk) disable iff (sys_rst)
    ($past(state) == ST_HOLD_HIGH && state == ST_HOLD_LOW) |->
      $past(selObs.fall) && $past(cnt) == HIGH_HOLD_PULSES)
    else $error("stretched high phase cut short");

  a_low_exit: assert property (
    @(posedge clk) disable iff (sys_rst)
    ($past(state) == ST_HOLD_LOW && state == ST_FOLLOW) |->
      $past(selObs.fall) && $past(cnt) == LOW_EDGES - 3'h1)
    else $error("low stage left off a falling edge");

  a_dead_branch: assert property (
    @(posedge clk) disable iff (sys_rst)
    ($past(state) == ST_DRAIN && state == ST_HOLD_HIGH) |->
      $past(selObs.level) && $past(oldDead))
    else $error("high hold entered without a dead high input");

  a_sel_match: assert property (
    @(posedge clk) disable iff (sys_rst)
    (state == ST_FOLLOW && strapTaken && !wantSwitch) |->
      muxLevel == (selSync ? obsB.level : obsA.level))
    else $error("output not from the selected input");

  a_dead_low: assert property (
    @(posedge clk) disable iff (sys_rst)
    ($past(state) == ST_DRAIN && state == ST_HOLD_LOW &&
      !$past(drainDone)) |-> $past(oldDead) && !$past(selObs.level))
    else $error("low hold entered without a dead low input");

  a_busy_start: assert property (
    @(posedge clk) disable iff (sys_rst)
    $rose(switchBusy) |-> $past(wantSwitch) && !$past(bypass))
    else $error("switchover began without a synchronised select");

  a_strap_once: assert property (
    @(posedge clk) disable iff (sys_rst)
    $past(strapTaken) |-> $stable(bypass))
    else $error("strap mode changed after it was caught");

  a_bypass_idle: assert property (
    @(posedge clk) disable iff (sys_rst)
    (strapTaken && bypass) |-> !switchBusy)
    else $error("plain mux entered a staged switchover");

  a_reverse_keep: assert property (
    @(posedge clk) disable iff (sys_rst)
    ($past(state) == ST_DRAIN && state == ST_FOLLOW) |->
      curSel == $past(curSel))
    else $error("cancelled switch moved the input");
endmodule
`default_nettype wire

// >>> gcs_pkg.sv
`default_nettype none
package gcs_pkg;
  // ==========================================================
  // fanout and select
  localparam int FANOUT_WIDTH = 10;
  localparam logic SEL_RESET = 1'h0; // input a after reset
  localparam logic LEVEL_RESET = 1'h0;
  localparam logic STRAP_RESET = 1'h0;

  // ==========================================================
  // stage lengths, counted in edges of an input clock
  localparam logic [2:0] CNT_RESET = 3'h0;
  localparam logic [2:0] DRAIN_PULSES = 3'h4; // old pulses
  localparam logic [2:0] DEAD_NEW_EDGES = 3'h3; // old silent
  localparam logic [2:0] HIGH_HOLD_PULSES = 3'h2;
  localparam logic [2:0] LOW_EDGES = 3'h3; // new falls, low
  localparam logic [4:0] SWITCH_MAX_CYCLES = 5'h11; // 17

  // ==========================================================
  // carriers
  typedef struct packed {
    logic level; // last valid level
    logic rise;  // one-cycle rising edge
    logic fall;  // one-cycle falling edge
  } gcs_obs_type;

  typedef struct packed {
    logic [FANOUT_WIDTH-1:0] q;  // true outputs
    logic [FANOUT_WIDTH-1:0] qn; // complement outputs
  } gcs_fanout_type;

  typedef enum logic [1:0] {
    ST_FOLLOW,
    ST_DRAIN,
    ST_HOLD_HIGH,
    ST_HOLD_LOW
  } gcs_state_type;
endpackage
`default_nettype wire

// >>> gcs_edge_track.sv
`timescale 1ns/1ps
`default_nettype none
module gcs_edge_track (
  input wire logic clk, // system clock
  input wire logic sys_rst, // async reset, high
  input wire logic ce, // clock enable
  input wire logic clockPin, // sampled input clock
  input wire logic ampOk, // amplitude above threshold
  output gcs_pkg::gcs_obs_type obs // level and edges
);
  import gcs_pkg::*;

  logic level;
  logic prevLevel;

  // ==========================================================
  // dead-input guard: a weak input freezes at its last level,
  // so a floating pin can never make edges or odd levels
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      level <= LEVEL_RESET;
      prevLevel <= LEVEL_RESET;
    end else if (ce) begin
      if (ampOk) begin
        level <= clockPin;
      end
      prevLevel <= level;
    end
  end

  // edges come only from the held level
  assign obs.level = level;
  assign obs.rise = ce & level & ~prevLevel;
  assign obs.fall = ce & ~level & prevLevel;

  // ==========================================================
  // checks
  a_weak_hold: assert property (
    @(posedge clk) disable iff (sys_rst)
    !ampOk |=> level == $past(level))
    else $error("level moved while amplitude was low");

  a_static_quiet: assert property (
    @(posedge clk) disable iff (sys_rst)
    (!ampOk ##1 !ampOk) |-> !(obs.rise || obs.fall))
    else $error("edge seen from a dead input");
endmodule
`default_nettype wire

// >>> gcs_out_gate.sv
`timescale 1ns/1ps
`default_nettype none
module gcs_out_gate (
  input wire logic clk, // system clock
  input wire logic sys_rst, // async reset, high
  input wire logic ce, // clock enable
  input wire logic enable, // output enable, high
  input wire logic muxLevel, // chosen clock level
  output gcs_pkg::gcs_fanout_type fanout // ten copies
);
  import gcs_pkg::*;

  logic gateOpen;
  logic prevMux;
  wire muxFall = ~muxLevel & prevMux;
  // the gate only moves on a falling edge: no runt either way
  wire next_gateOpen = muxFall ? enable : gateOpen;
  wire next_level = next_gateOpen & muxLevel;

  // ==========================================================
  // gate and registered fanout
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      gateOpen <= LEVEL_RESET;
      prevMux <= LEVEL_RESET;
      fanout.q <= '0;
      fanout.qn <= '1;
    end else if (ce) begin
      gateOpen <= next_gateOpen;
      prevMux <= muxLevel;
      fanout.q <= {FANOUT_WIDTH{next_level}};
      fanout.qn <= {FANOUT_WIDTH{~next_level}};
    end
  end

  // ==========================================================
  // checks
  a_gate_close: assert property (
    @(posedge clk) disable iff (sys_rst)
    $fell(gateOpen) |-> $past(muxFall) && !$past(enable))
    else $error("gate closed away from a falling edge");

  a_gate_open: assert property (
    @(posedge clk) disable iff (sys_rst)
    $rose(gateOpen) |-> $past(muxFall) && $past(enable))
    else $error("gate opened away from a falling edge");

  a_fanout_same: assert property (
    @(posedge clk) disable iff (sys_rst)
    fanout.q == {FANOUT_WIDTH{fanout.q[0]}} && fanout.qn == ~fanout.q)
    else $error("fanout copies differ");
endmodule
`default_nettype wire

// >>> gcs_clk_src.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// two clock sources, each able to run, stick or float
module gcs_clk_src (
  input wire logic clk, // bench clock
  input wire logic [7:0] halfA, // half period of a, in clk cycles
  input wire logic [7:0] halfB, // half period of b, in clk cycles
  input wire logic [1:0] modeA, // 0 run, 1 stuck, 2 floating
  input wire logic [1:0] modeB, // same for b
  output logic clockInputA, // first source
  output logic clockInputB // second source
);
  logic [7:0] cntA = 8'h00;
  logic [7:0] cntB = 8'h00;
  logic [1:0] mA;
  logic [1:0] mB;
  initial clockInputA = 1'b0;
  initial clockInputB = 1'b0;
  // modes read at the edge, pins moved just after it
  always @(posedge clk) begin
    mA = modeA;
    mB = modeB;
    #1;
    // floating line shows a changing pattern, never a held value
    if (mA == 2'h2) clockInputA = ~clockInputA;
    else if (mA == 2'h0) begin
      cntA = cntA + 8'h01;
      // half periods 4 and 5 keep the ratio at 1.25
      if (cntA >= halfA) begin
        cntA = 8'h00;
        clockInputA = ~clockInputA;
      end
    end
    if (mB == 2'h2) clockInputB = ~clockInputB;
    else if (mB == 2'h0) begin
      cntB = cntB + 8'h01;
      if (cntB >= halfB) begin
        cntB = 8'h00;
        clockInputB = ~clockInputB;
      end
    end
  end
endmodule
`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import gcs_pkg::*;
  logic clk, sysRst, ce, ampOkA, ampOkB, select, enable, porDelayStrap;
  logic clockInputA, clockInputB, runtSuppression, switchBusy;
  logic [1:0] modeA, modeB;
  gcs_fanout_type fanout;
  int errCount, testsRun, cycles, run;
  logic lastQ0;

  // ==========================================================
  // clock, sources and device
  always #10 clk = ~clk;
  gcs_clk_src src (.clk(clk), .halfA(8'h04), .halfB(8'h05),
    .modeA(modeA), .modeB(modeB), .clockInputA(clockInputA),
    .clockInputB(clockInputB));
  gcs_switchover_mux dut (.clk(clk), .sys_rst(sysRst), .ce(ce),
    .clockInputA(clockInputA), .clockInputB(clockInputB),
    .ampOkA(ampOkA), .ampOkB(ampOkB), .select(select), .enable(enable),
    .porDelayStrap(porDelayStrap), .fanout(fanout),
    .runtSuppression(runtSuppression), .switchBusy(switchBusy));

  // ==========================================================
  // checking and closing
  task automatic check(input string name, input logic [31:0] seen,
    input logic [31:0] exp);
    testsRun++;
    if (seen !== exp) begin
      errCount++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic final_report;
    if (errCount == 0 && testsRun > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // hang guard, far above the several hundred cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errCount++;
      final_report;
    end
  end
  // no output phase shorter than the fastest source half period
  always @(negedge clk) begin
    if (sysRst) run = 0;
    else if (fanout.q[0] !== lastQ0) begin
      if (run != 0 && runtSuppression === 1'b1) check("min_phase",
        run >= 4, 1);
      run = 1;
    end else if (run != 0) run++;
    lastQ0 = fanout.q[0];
  end

  // ==========================================================
  // helpers
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // wait until a pin has just reached the given level
  task automatic wait_edge(input logic b, input logic lvl);
    logic p, c;
    p = b ? clockInputB : clockInputA;
    for (int k = 0; k < 100; k++) begin
      @(negedge clk);
      c = b ? clockInputB : clockInputA;
      if (c === lvl && p !== lvl) break;
      p = c;
    end
  endtask
  // q lags the chosen pin by two edges while following
  task automatic follow_chk(input logic s);
    logic p0, p1, p2;
    p1 = 1'b0;
    p2 = 1'b0;
    for (int k = 0; k < 40; k++) begin
      @(negedge clk);
      p0 = s ? clockInputB : clockInputA;
      if (k >= 2) check("q_follow", fanout.q, {FANOUT_WIDTH{p2}});
      check("qn_inv", fanout.qn ^ fanout.q, {FANOUT_WIDTH{1'b1}});
      p2 = p1;
      p1 = p0;
    end
  endtask
  // mode 0 running, 1 old stuck high, 2 old stuck low
  task automatic switch_to(input logic s, input int mode);
    int rises, hiRises;
    logic prev, cur, hi, lq;
    @(posedge clk) #1 select = s;
    rises = 0;
    hiRises = 0;
    hi = 1'b0;
    lq = 1'b1;
    prev = s ? clockInputB : clockInputA;
    for (int k = 0; k < 400; k++) begin
      @(negedge clk);
      cur = s ? clockInputB : clockInputA;
      if (cur && !prev) rises++;
      if (cur && !prev && fanout.q[0] === 1'b1) hiRises++;
      prev = cur;
      if (k == 5) check("busy", switchBusy, 1);
      if (k == 5 && mode == 1) check("hold_hi", fanout.q[0], 1);
      if (k > 5 && switchBusy !== 1'b1) break;
      lq = fanout.q[0];
      if (fanout.q[0] !== 1'b0) hi = 1'b1;
    end
    check("low_stage", lq, 0);
    if (mode == 2) check("hold_lo", hi, 0);
    // stuck high: silent-old wait plus the high hold, all while high
    if (mode == 1) check("hi_pulses",
      hiRises >= DEAD_NEW_EDGES + HIGH_HOLD_PULSES, 1);
    check("sw_len", rises <= 17, 1);
    check("done", switchBusy, 0);
  endtask
  task automatic do_reset(input logic strap);
    @(posedge clk) #1 sysRst = 1'b1;
    porDelayStrap = strap;
    cyc(2);
    check("rst_q", fanout.q, 0);
    check("rst_qn", fanout.qn, {FANOUT_WIDTH{1'b1}});
    check("rst_busy", switchBusy, 0);
    check("rst_rs", runtSuppression, 0);
    @(posedge clk) #1 sysRst = 1'b0;
    // output stays low until the chosen clock first falls
    cyc(3);
    check("rst_gate", fanout.q, 0);
    cyc(17);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_run_switch;
    check("rs_on", runtSuppression, 1);
    follow_chk(0);
    switch_to(1, 0);
    follow_chk(1);
  endtask
  task automatic t_stuck_high;
    wait_edge(1, 1);
    @(posedge clk) #1 modeB = 2'h1;
    cyc(10);
    switch_to(0, 1);
    follow_chk(0);
  endtask
  task automatic t_fail_safe;
    wait_edge(0, 0);
    @(posedge clk) #1 ampOkA = 1'b0;
    modeA = 2'h2;
    modeB = 2'h0;
    cyc(3);
    for (int k = 0; k < 20; k++) begin
      @(negedge clk);
      check("fs_hold", fanout.q, 0);
    end
    switch_to(1, 2);
    follow_chk(1);
    @(posedge clk) #1 ampOkA = 1'b1;
    modeA = 2'h0;
  endtask
  task automatic t_enable;
    @(posedge clk) #1 enable = 1'b0;
    cyc(20);
    for (int k = 0; k < 10; k++) begin
      @(negedge clk);
      check("dis_q", fanout.q, 0);
      check("dis_qn", fanout.qn, {FANOUT_WIDTH{1'b1}});
    end
    wait_edge(1, 1);
    @(posedge clk) #1 enable = 1'b1;
    cyc(2);
    check("en_wait", fanout.q, 0);
    cyc(12);
    follow_chk(1);
  endtask
  task automatic t_bypass;
    do_reset(1);
    check("rs_off", runtSuppression, 0);
    follow_chk(1);
    @(posedge clk) #1 select = 1'b0;
    for (int k = 0; k < 8; k++) begin
      @(negedge clk);
      check("no_stage", switchBusy, 0);
    end
    follow_chk(0);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    clk = 1'b0;
    sysRst = 1'b1;
    ce = 1'b1;
    ampOkA = 1'b1;
    ampOkB = 1'b1;
    select = 1'b0;
    enable = 1'b1;
    porDelayStrap = 1'b0;
    modeA = 2'h0;
    modeB = 2'h0;
    errCount = 0;
    testsRun = 0;
    cycles = 0;
    run = 0;
    lastQ0 = 1'b0;
    do_reset(0);
    t_run_switch;
    t_stuck_high;
    t_fail_safe;
    t_enable;
    t_bypass;
    final_report;
  end
endmodule
`default_nettype wire
